// ===== hw/opw_top.sv
// Two-wire slave, threshold bank and power warning comparators
`timescale 1ns/1ps
`default_nettype none
`include "opw_consts.svh"

module opw_top
  import opw_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rst,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       sda_out,
  output logic       sda_oe,
  input  wire logic  manufacturer_password_level,
  input  wire logic  meas_valid,
  input  wire opw_meas_s meas,
  output opw_warn_s  warning_flag
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; a level counts only once stages two and three agree,
  // which also rejects single-cycle glitches on the slow bus.
  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic       scl_f_r;
  logic       sda_f_r;
  logic       scl_f_nxt;
  logic       sda_f_nxt;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], scl_in};
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
    end
  end

  assign scl_f_nxt = (scl_sync_r[1] == scl_sync_r[2]) ? scl_sync_r[2] : scl_f_r;
  assign sda_f_nxt = (sda_sync_r[1] == sda_sync_r[2]) ? sda_sync_r[2] : sda_f_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      scl_f_r <= scl_f_nxt;
      sda_f_r <= sda_f_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  wire scl_rise  = scl_f_nxt && !scl_f_r;
  wire scl_fall  = !scl_f_nxt && scl_f_r;
  wire bus_start = scl_f_r && scl_f_nxt && sda_f_r && !sda_f_nxt;
  wire bus_stop  = scl_f_r && scl_f_nxt && !sda_f_r && sda_f_nxt;

  // ----------------------------------------------------------------
  // Slave state
  // ----------------------------------------------------------------
  opw_state_e state_r;
  opw_state_e state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic       first_r;
  logic       first_nxt;
  logic       nack_r;
  logic       nack_nxt;
  logic       oe_r;
  logic       oe_nxt;
  logic       wr_en;
  logic [7:0] rdata;
  opw_thresh_s thr;

  wire addr_match = (sh_r[7:1] == `OPW_DEV_ADDR);
  wire byte_done  = (cnt_r == `OPW_BYTE_BITS);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    ptr_nxt   = ptr_r;
    first_nxt = first_r;
    nack_nxt  = nack_r;
    oe_nxt    = oe_r;
    wr_en     = 1'b0;
    if (bus_start) begin
      state_nxt = ST_ADDR;
      cnt_nxt   = 4'h0;
      oe_nxt    = 1'b0;
    end else if (bus_stop) begin
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          oe_nxt = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sda_f_r};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && byte_done) begin
            // Other addresses are simply not acknowledged
            state_nxt = addr_match ? ST_AACK : ST_IDLE;
            oe_nxt    = addr_match;
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (sh_r[0]) begin
              sh_nxt    = rdata;
              oe_nxt    = !rdata[7];
              state_nxt = ST_TX;
            end else begin
              first_nxt = 1'b1;
              oe_nxt    = 1'b0;
              state_nxt = ST_RX;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sda_f_r};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && byte_done) begin
            // First data byte is the offset, later ones are stored
            if (first_r) begin
              ptr_nxt = sh_r;
            end else begin
              wr_en   = 1'b1;
              ptr_nxt = ptr_r + 8'h01;
            end
            oe_nxt    = 1'b1;
            state_nxt = ST_RACK;
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            first_nxt = 1'b0;
            cnt_nxt   = 4'h0;
            oe_nxt    = 1'b0;
            state_nxt = ST_RX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'h7) begin
              oe_nxt    = 1'b0;
              state_nxt = ST_TACK;
            end else begin
              sh_nxt  = {sh_r[6:0], 1'b0};
              oe_nxt  = !sh_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            // Pointer moves early so the next byte is ready by the fall
            nack_nxt = sda_f_r;
            ptr_nxt  = ptr_r + 8'h01;
          end else if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (nack_r) begin
              state_nxt = ST_IDLE;
            end else begin
              sh_nxt    = rdata;
              oe_nxt    = !rdata[7];
              state_nxt = ST_TX;
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          oe_nxt    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
      sh_r    <= 8'h00;
      ptr_r   <= 8'h00;
      first_r <= 1'b0;
      nack_r  <= 1'b0;
      oe_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      ptr_r   <= ptr_nxt;
      first_r <= first_nxt;
      nack_r  <= nack_nxt;
      oe_r    <= oe_nxt;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = oe_r;

  // ----------------------------------------------------------------
  // Threshold bank
  // ----------------------------------------------------------------
  opw_store u_store (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .wr_en     (wr_en),
    .addr      (ptr_r),
    .wdata     (sh_r),
    .mfr_level (manufacturer_password_level),
    .rdata_r   (rdata),
    .thr       (thr)
  );

  // ----------------------------------------------------------------
  // Warning comparators
  // ----------------------------------------------------------------
  // Raw upper bytes only, unsigned; lower bytes never take part, so
  // a threshold of 25.6uW steps is the true resolution.
  wire tx_low_cmp  = meas.tx_u < thr.tx_low_u;
  wire rx_high_cmp = meas.rx_u > thr.rx_high_u;
  wire rx_low_cmp  = meas.rx_u < thr.rx_low_u;

  opw_warn_s warn_nxt;
  assign warn_nxt = meas_valid ? opw_warn_s'{tx_low_cmp, rx_high_cmp, rx_low_cmp}
                               : warning_flag;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      warning_flag <= '0;
    end else begin
      warning_flag <= warn_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  tx_low_flag_a: assert property (
    meas_valid |=> warning_flag.tx_low == ($past(meas.tx_u) < $past(thr.tx_low_u)))
    else $error("tx low warning mismatch");

  rx_high_flag_a: assert property (
    meas_valid |=> warning_flag.rx_high == ($past(meas.rx_u) > $past(thr.rx_high_u)))
    else $error("rx high warning mismatch");

  rx_low_flag_a: assert property (
    meas_valid |=> warning_flag.rx_low == ($past(meas.rx_u) < $past(thr.rx_low_u)))
    else $error("rx low warning mismatch");

  lower_ignored_a: assert property (
    meas_valid && meas.tx_u == thr.tx_low_u && thr.tx_low_l != 8'h00
      |=> !warning_flag.tx_low)
    else $error("lower byte affected tx low warning");

  unsigned_cmp_a: assert property (
    meas_valid && meas.rx_u[7] && !thr.rx_high_u[7] |=> warning_flag.rx_high)
    else $error("rx high compare not unsigned");

  flags_hold_a: assert property (
    !meas_valid |=> $stable(warning_flag))
    else $error("warning flags moved without a new result");

  write_on_bus_a: assert property (
    wr_en |=> sda_oe)
    else $error("data byte not acknowledged");

  ack_drive_a: assert property (
    state_r == ST_AACK |-> sda_oe)
    else $error("address acknowledge not driven");

endmodule

`default_nettype wire

// ===== hw/opw_consts.svh
// Constants for the optical power warning threshold bank
// Summary of operation
// - TX low flag when measured upper below threshold
// - RX high flag when measured upper above threshold
// - RX low flag when measured upper below threshold
// - Lower threshold bytes stored, never compared
// - Upper byte weighs 25.6 microwatts per bit
// - Upper and lower form sixteen bits, 0.1uW
// - Thresholds are unsigned binary numbers
// - Compare raw values, no calibration applied
// - Check byte is plain storage, no summing
// - Check byte writable at manufacturer level
// - Check byte read-only at customer level
// - TX measurement is result register upper byte
`ifndef OPW_CONSTS_SVH
`define OPW_CONSTS_SVH

// ----------------------------------------------------------------
// Serial bus
// ----------------------------------------------------------------
`define OPW_DEV_ADDR      7'h51
`define OPW_BYTE_BITS     4'h8

// ----------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------
`define OPW_OFS_TX_LOW_U  8'h1E
`define OPW_OFS_TX_LOW_L  8'h1F
`define OPW_OFS_RX_HIGH_U 8'h24
`define OPW_OFS_RX_HIGH_L 8'h25
`define OPW_OFS_RX_LOW_U  8'h26
`define OPW_OFS_RX_LOW_L  8'h27
`define OPW_OFS_CHECK     8'h5F

// ----------------------------------------------------------------
// Reset values and weights
// ----------------------------------------------------------------
`define OPW_RST_BYTE      8'h00
`define OPW_NUM_BYTES     7
`define OPW_CHECK_IDX     6
`define OPW_UPPER_LSB_NW  25600
`define OPW_LOWER_LSB_NW  100

`endif

// ===== hw/opw_pkg.sv
// Types shared by the optical power warning threshold bank
package opw_pkg;

  // ----------------------------------------------------------------
  // Serial slave states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RACK, ST_TX, ST_TACK
  } opw_state_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] tx_low_u;
    logic [7:0] tx_low_l;
    logic [7:0] rx_high_u;
    logic [7:0] rx_high_l;
    logic [7:0] rx_low_u;
    logic [7:0] rx_low_l;
  } opw_thresh_s;

  typedef struct packed {
    logic [7:0] tx_u;
    logic [7:0] rx_u;
  } opw_meas_s;

  typedef struct packed {
    logic tx_low;
    logic rx_high;
    logic rx_low;
  } opw_warn_s;

endpackage

// ===== hw/opw_store.sv
// Byte store for the threshold pairs and the check byte
`timescale 1ns/1ps
`default_nettype none
`include "opw_consts.svh"

module opw_store
  import opw_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        mfr_level,
  output logic      [7:0]  rdata_r,
  output opw_thresh_s      thr
);

  localparam logic [7:0] OFS_TAB [`OPW_NUM_BYTES] = '{
    `OPW_OFS_TX_LOW_U, `OPW_OFS_TX_LOW_L, `OPW_OFS_RX_HIGH_U,
    `OPW_OFS_RX_HIGH_L, `OPW_OFS_RX_LOW_U, `OPW_OFS_RX_LOW_L, `OPW_OFS_CHECK
  };

  logic [7:0] byte_r   [`OPW_NUM_BYTES];
  logic [7:0] rd_term  [`OPW_NUM_BYTES];
  wire logic [`OPW_NUM_BYTES-1:0] hit;
  logic [7:0] rdata_nxt;

  // ----------------------------------------------------------------
  // Storage entries
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `OPW_NUM_BYTES; gi = gi + 1) begin : g_ent
      // Check byte is only plain storage; nothing sums the page
      wire wr_ok = (gi != `OPW_CHECK_IDX) || mfr_level;
      assign hit[gi]     = (addr == OFS_TAB[gi]);
      assign rd_term[gi] = hit[gi] ? byte_r[gi] : 8'h00;
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          byte_r[gi] <= `OPW_RST_BYTE;
        end else if (wr_en && hit[gi] && wr_ok) begin
          byte_r[gi] <= wdata;
        end
      end
    end
  endgenerate

  // Unmapped offsets read as zero
  always_comb begin
    rdata_nxt = 8'h00;
    for (int i = 0; i < `OPW_NUM_BYTES; i++) begin
      rdata_nxt = rdata_nxt | rd_term[i];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign thr = '{byte_r[0], byte_r[1], byte_r[2], byte_r[3], byte_r[4], byte_r[5]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  check_locked_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_en && addr == `OPW_OFS_CHECK && !mfr_level |=> $stable(byte_r[`OPW_CHECK_IDX]))
    else $error("check byte changed without manufacturer level");

  check_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_en && addr == `OPW_OFS_CHECK && mfr_level |=> byte_r[`OPW_CHECK_IDX] == $past(wdata))
    else $error("check byte write lost at manufacturer level");

  lower_store_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_en && addr == `OPW_OFS_RX_LOW_L |=> thr.rx_low_l == $past(wdata))
    else $error("lower byte not stored");

endmodule

`default_nettype wire

// ===== verif/opw_host.sv
// Two-wire host controller model driving the threshold bank
`timescale 1ns/1ps
`default_nettype none

module opw_host (
  input  wire logic ref_clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda
);
  // ----------------------------------------------------------------
  // Bus phases, 1 on an output means released to the pull-up
  // ----------------------------------------------------------------
  localparam int HALF = 10;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hold();
    repeat (HALF) @(posedge ref_clk);
  endtask
  // Also serves as repeated start from a low clock
  task automatic start();
    sda <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda <= 1'b0;
    hold();
    scl <= 1'b0;
  endtask
  task automatic stop();
    hold();
    sda <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda <= 1'b1;
    hold();
  endtask
  // Data moves only while the clock is low
  task automatic xbit(input logic b, output logic r);
    hold();
    sda <= b;
    hold();
    scl <= 1'b1;
    hold();
    r = sda_w;
    scl <= 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] w, input logic a, output logic [7:0] r,
                       output logic ack);
    for (int i = 7; i >= 0; i--) xbit(w[i], r[i]);
    xbit(a, ack);
  endtask
endmodule

`default_nettype wire

// ===== verif/test_opw_top.sv
// Self-checking bench for the optical power warning threshold bank
`timescale 1ns/1ps
`default_nettype none
`include "opw_consts.svh"

module test_opw_top;
  import opw_pkg::*;
  logic        ref_clk, rst, mfr, meas_valid, sda_oe, sda_out, scl_h, sda_h;
  opw_meas_s   meas;
  opw_warn_s   flags;
  int          mismatches, samples_checked, cycles;
  logic [31:0] seed;
  logic [7:0]  tv [6];
  logic [7:0]  ofs [7];
  logic [7:0]  d;
  logic        nk;
  logic [7:0]  cv [5];
  wire  logic  sda_w = sda_h & ~(sda_oe & ~sda_out);

  opw_top u_opw_top (.ref_clk(ref_clk), .rst(rst), .scl_in(scl_h), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .manufacturer_password_level(mfr),
    .meas_valid(meas_valid), .meas(meas), .warning_flag(flags));
  opw_host u_opw_host (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl_h), .sda(sda_h));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Roughly 25 bus transfers of about 1150 cycles each
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches++;
      print_verdict();
    end
  end
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Only upper bytes matter, lower bytes never enter the compare
  function automatic logic [2:0] exp_flags(input logic [7:0] tx, input logic [7:0] rx);
    return {tx < tv[0], rx > tv[2], rx < tv[4]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] o, input logic [15:0] v, input int n);
    logic [7:0] r;
    logic       a;
    u_opw_host.start();
    u_opw_host.xbyte({`OPW_DEV_ADDR, 1'b0}, 1'b1, r, a);
    chk("address ack", {7'h00, a}, 8'h00);
    u_opw_host.xbyte(o, 1'b1, r, a);
    for (int i = 0; i < n; i++) u_opw_host.xbyte(v[15-8*i -: 8], 1'b1, r, a);
    u_opw_host.stop();
  endtask
  task automatic rd(input logic [7:0] o, output logic [7:0] v);
    logic [7:0] r;
    logic       a;
    u_opw_host.start();
    u_opw_host.xbyte({`OPW_DEV_ADDR, 1'b0}, 1'b1, r, a);
    u_opw_host.xbyte(o, 1'b1, r, a);
    u_opw_host.start();
    u_opw_host.xbyte({`OPW_DEV_ADDR, 1'b1}, 1'b1, r, a);
    u_opw_host.xbyte(8'hFF, 1'b1, v, a);
    u_opw_host.stop();
  endtask
  task automatic mchk(input logic [7:0] tx, input logic [7:0] rx);
    @(posedge ref_clk);
    meas_valid <= 1'b1;
    meas <= '{tx_u: tx, rx_u: rx};
    @(posedge ref_clk);
    meas_valid <= 1'b0;
    @(negedge ref_clk);
    chk("warning_flag", {5'h00, flags}, {5'h00, exp_flags(tx, rx)});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    mfr = 1'b0;
    meas_valid = 1'b0;
    meas = '0;
    cycles = 0;
    seed = 32'h0000_003D;
    ofs = '{`OPW_OFS_TX_LOW_U, `OPW_OFS_TX_LOW_L, `OPW_OFS_RX_HIGH_U, `OPW_OFS_RX_HIGH_L,
            `OPW_OFS_RX_LOW_U, `OPW_OFS_RX_LOW_L, `OPW_OFS_CHECK};
    cv = '{8'h00, 8'h7F, 8'h80, 8'h81, 8'hFF};
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    for (int i = 0; i < 7; i++) begin
      rd(ofs[i], d);
      chk("reset value", d, 8'h00);
    end
    $display("test reset values done");
    for (int i = 0; i < 6; i++) tv[i] = xs() | 8'h01;
    for (int p = 0; p < 3; p++) wr(ofs[2*p], {tv[2*p], tv[2*p+1]}, 2);
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i], d);
      chk("threshold byte", d, tv[i]);
    end
    $display("test threshold readback done");
    wr(`OPW_OFS_CHECK, 16'h5A00, 1);
    rd(`OPW_OFS_CHECK, d);
    chk("check byte customer", d, 8'h00);
    @(posedge ref_clk) mfr <= 1'b1;
    wr(`OPW_OFS_CHECK, 16'hA500, 1);
    rd(`OPW_OFS_CHECK, d);
    chk("check byte manufacturer", d, 8'hA5);
    @(posedge ref_clk) mfr <= 1'b0;
    $display("test check byte done");
    wr(8'h30, 16'hC300, 1);
    rd(8'h30, d);
    chk("unmapped byte", d, 8'h00);
    u_opw_host.start();
    u_opw_host.xbyte({`OPW_DEV_ADDR ^ 7'h02, 1'b0}, 1'b1, d, nk);
    chk("foreign address ack", {7'h00, nk}, 8'h01);
    u_opw_host.stop();
    $display("test refusals done");
    mchk(tv[0], tv[2]);
    mchk(tv[0] - 8'h01, tv[4]);
    for (int i = 0; i < 100; i++) mchk(xs(), xs());
    $display("test random measurements done");
    d = {5'h00, flags};
    for (int p = 0; p < 3; p++) begin
      tv[2*p] = 8'h80;
      tv[2*p+1] = 8'h00;
      wr(ofs[2*p], 16'h8000, 2);
    end
    chk("flags held", {5'h00, flags}, d);
    foreach (cv[i]) foreach (cv[j]) mchk(cv[i], cv[j]);
    $display("test boundary measurements done");
    print_verdict();
  end
endmodule

`default_nettype wire
